/* File: hdl/acd_pkg.sv */
// Shared constants and types of the ADC command decoder
`default_nettype none
package acd_pkg;
   // Command opcodes, compared against byte[7:1], byte[7:4] or, for GC_RESET, the whole byte
   localparam logic [6:0] OP_RESET = 7'h03;
   localparam logic [6:0] OP_START = 7'h04;
   localparam logic [6:0] OP_SLEEP = 7'h01;
   localparam logic [3:0] OP_FETCH = 4'h1;
   localparam logic [3:0] OP_RDREG = 4'h2;
   localparam logic [3:0] OP_WRREG = 4'h4;
   localparam logic [7:0] GC_RESET = 8'h06;
   localparam logic [6:0] GC_ADDR  = 7'h00;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h40;
   // Configuration register fields
   localparam logic [1:0] MODE_REG = 2'h1;
   localparam int         MODE_BIT = 4;
   localparam logic [1:0] STAT_REG = 2'h2;
   localparam int         STAT_BIT = 7;
   localparam int         DCNT_BIT = 6;
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [3:0] LAST_BIT = 4'h8;
   // Event kinds {general call, not first byte}
   localparam logic [1:0] K_CMD  = 2'h0;
   localparam logic [1:0] K_DATA = 2'h1;
   localparam logic [1:0] K_GC   = 2'h2;
   localparam int         EVT_W  = 10;
   localparam int         TX_W   = 24;

   typedef enum logic [2:0] {
      L_IDLE  = 3'h0,
      L_ADDR  = 3'h1,
      L_ACKA  = 3'h3,
      L_WRITE = 3'h2,
      L_ACKW  = 3'h6,
      L_READ  = 3'h7,
      L_ACKR  = 3'h5
   } acd_link_e;

   typedef struct packed {
      acd_link_e   st;
      logic [2:0]  scl;
      logic [2:0]  sda;
      logic [7:0]  sh;
      logic [3:0]  cnt;
      logic        rw;
      logic        gc;
      logic        first;
      logic        nack;
      logic        sda_oe;
      logic [23:0] tx;
      logic        evt_tgl;
      logic [9:0]  evt_dat;
   } acd_link_s;

   typedef struct packed {
      logic [3:0][7:0] cfg;
      logic [15:0]     result;
      logic [7:0]      cnt;
      logic            stat;
      logic            rdy;
      logic            conv;
      logic            sleep_pend;
      logic            pwr_down;
      logic            wr_pend;
      logic [1:0]      wr_addr;
      logic            tx_tgl;
      logic [23:0]     tx_dat;
      logic            conv_start;
      logic            filt_clr;
   } acd_sys_s;
endpackage
`default_nettype wire

/* File: hdl/acd_hs_if.sv */
// Toggle handshake carrying one word between clock domains
`default_nettype none
interface acd_hs_if #(parameter int W = 8);
   logic         tgl;
   logic [W-1:0] dat;
   modport src (output tgl, output dat);
   modport dst (input tgl, input dat);
endinterface
`default_nettype wire

/* File: hdl/acd_hs_rx.sv */
// Receiving end of the toggle handshake
`default_nettype none
module acd_hs_rx #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   acd_hs_if.dst             hs,
   output logic              vld_o,
   output logic [W-1:0]      dat_o
);
   typedef struct packed {
      logic [2:0]   sync;
      logic         vld;
      logic [W-1:0] dat;
   } acd_hsr_s;
   acd_hsr_s s;
   acd_hsr_s n;

   // Word is stable long before the toggle lands, so no sync on data
   always_comb begin
      n = s;
      n.sync = {s.sync[1:0], hs.tgl};
      n.vld = s.sync[2] ^ s.sync[1];
      if (s.sync[2] ^ s.sync[1]) begin
         n.dat = hs.dat;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign vld_o = s.vld;
   assign dat_o = s.dat;
endmodule
`default_nettype wire

/* File: hdl/acd_i2c_link.sv */
// Serial target front end on the oversampling link clock
`default_nettype none
module acd_i2c_link #(
   parameter logic [6:0] DEV_ADDR = acd_pkg::DEV_ADDR_DEF
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   input  wire logic         tx_v_i,
   input  wire logic [23:0]  tx_dat_i,
   acd_hs_if.src             evt,
   output logic              sda_oe_o
);
   acd_pkg::acd_link_s s;
   acd_pkg::acd_link_s n;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   // Index 0 is the raw capture; only index 1 and 2 feed logic
   assign rise  = s.scl[1] & ~s.scl[2];
   assign fall  = ~s.scl[1] & s.scl[2];
   assign start = s.scl[1] & s.scl[2] & s.sda[2] & ~s.sda[1];
   assign stop  = s.scl[1] & s.scl[2] & ~s.sda[2] & s.sda[1];

   always_comb begin
      n = s;
      n.scl = {s.scl[1:0], scl_i};
      n.sda = {s.sda[1:0], sda_i};
      if (tx_v_i) begin
         n.tx = tx_dat_i;
      end
      if (rise) begin
         if (s.st inside {acd_pkg::L_ADDR, acd_pkg::L_WRITE, acd_pkg::L_READ}) begin
            n.cnt = s.cnt + 4'h1;
         end
         if (s.st == acd_pkg::L_ADDR || s.st == acd_pkg::L_WRITE) begin
            n.sh = {s.sh[6:0], s.sda[1]};
         end
         if (s.st == acd_pkg::L_ACKR) begin
            n.nack = s.sda[1];
         end
      end
      if (fall) begin
         unique case (s.st)
            acd_pkg::L_IDLE: begin
            end
            acd_pkg::L_ADDR: if (s.cnt == acd_pkg::LAST_BIT) begin
               n.st = acd_pkg::L_IDLE;
               if (s.sh[7:1] == DEV_ADDR || (s.sh[7:1] == acd_pkg::GC_ADDR && !s.sh[0])) begin
                  n.st = acd_pkg::L_ACKA;
                  n.sda_oe = 1'h1;
                  n.rw = s.sh[0];
                  n.gc = (s.sh[7:1] == acd_pkg::GC_ADDR);
                  n.first = 1'h1;
                  n.nack = 1'h0;
               end
            end
            acd_pkg::L_ACKA, acd_pkg::L_ACKW, acd_pkg::L_ACKR: begin
               n.cnt = 4'h0;
               if (!s.rw) begin
                  n.st = acd_pkg::L_WRITE;
                  n.sda_oe = 1'h0;
               end else if (!s.nack) begin
                  // Bytes come from the local copy; a new result cannot tear them
                  n.st = acd_pkg::L_READ;
                  n.sh = s.tx[23:16];
                  n.tx = {s.tx[15:0], 8'h00};
                  n.sda_oe = ~s.tx[23];
               end else begin
                  n.st = acd_pkg::L_IDLE;
                  n.sda_oe = 1'h0;
               end
            end
            acd_pkg::L_WRITE: if (s.cnt == acd_pkg::LAST_BIT) begin
               n.st = acd_pkg::L_ACKW;
               n.sda_oe = 1'h1;
               n.first = 1'h0;
               n.evt_tgl = ~s.evt_tgl;
               n.evt_dat = {s.gc, ~s.first, s.sh};
            end
            acd_pkg::L_READ: begin
               if (s.cnt == acd_pkg::LAST_BIT) begin
                  n.st = acd_pkg::L_ACKR;
                  n.sda_oe = 1'h0;
               end else begin
                  n.sh = {s.sh[6:0], 1'h0};
                  n.sda_oe = ~s.sh[6];
               end
            end
            default: n.st = acd_pkg::L_IDLE;
         endcase
      end
      if (start) begin
         n.st = acd_pkg::L_ADDR;
         n.cnt = 4'h0;
         n.sda_oe = 1'h0;
      end
      if (stop) begin
         n.st = acd_pkg::L_IDLE;
         n.sda_oe = 1'h0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign evt.tgl = s.evt_tgl;
   assign evt.dat = s.evt_dat;
   assign sda_oe_o = s.sda_oe;

   chk_latch_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(s.evt_tgl) |-> $past(fall) && $past(s.cnt) == acd_pkg::LAST_BIT)
      else $error("command byte posted away from eighth falling edge");
endmodule
`default_nettype wire

/* File: hdl/acd_cmd_decoder.sv */
// Command decoder of the converter behind its serial target port
`default_nettype none
module acd_cmd_decoder #(
   parameter logic [6:0] DEV_ADDR = acd_pkg::DEV_ADDR_DEF
) (
   input  wire logic         CLK_SYS_I,
   input  wire logic         RESET_N_I,
   input  wire logic         LINK_CLK_I,
   input  wire logic         SCL_I,
   input  wire logic         SDA_I,
   output logic              SDA_O,
   output logic              SDA_OE_O,
   input  wire logic         CONV_DONE_I,
   input  wire logic [15:0]  CONV_DATA_I,
   output logic              CONV_START_O,
   output logic              FILTER_CLR_O,
   output logic              CONVERTING_O,
   output logic              POWER_DOWN_O,
   output logic              RDY_O,
   output logic              RDY_OE_O,
   output logic [31:0]       CFG_O
);
   acd_pkg::acd_sys_s s;
   acd_pkg::acd_sys_s n;

   logic              ev_v;
   logic [9:0]        ev_d;
   logic [1:0]        ev_k;
   logic [7:0]        ev_b;
   logic              tx_v;
   logic [23:0]       tx_d;
   logic              done;
   logic              wr_v;
   logic              cmd_v;
   logic              gc_rst;
   logic              c_reset;
   logic              c_start;
   logic              c_sleep;
   logic              c_fetch;
   logic              c_rdreg;
   logic              c_wrreg;
   logic [7:0]        rd_val;
   logic              cnt_on;

   acd_hs_if #(.W(acd_pkg::EVT_W)) evt_if ();
   acd_hs_if #(.W(acd_pkg::TX_W))  tx_if ();

   // Link side lives entirely on the link clock
   acd_i2c_link #(.DEV_ADDR(DEV_ADDR)) u_link (
      .clk_i    (LINK_CLK_I),
      .rst_n_i  (RESET_N_I),
      .scl_i    (SCL_I),
      .sda_i    (SDA_I),
      .tx_v_i   (tx_v),
      .tx_dat_i (tx_d),
      .evt      (evt_if.src),
      .sda_oe_o (SDA_OE_O)
   );

   acd_hs_rx #(.W(acd_pkg::EVT_W)) u_evt_rx (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RESET_N_I),
      .hs      (evt_if.dst),
      .vld_o   (ev_v),
      .dat_o   (ev_d)
   );

   acd_hs_rx #(.W(acd_pkg::TX_W)) u_tx_rx (
      .clk_i   (LINK_CLK_I),
      .rst_n_i (RESET_N_I),
      .hs      (tx_if.dst),
      .vld_o   (tx_v),
      .dat_o   (tx_d)
   );

   assign tx_if.tgl = s.tx_tgl;
   assign tx_if.dat = s.tx_dat;

   assign ev_k = ev_d[9:8];
   assign ev_b = ev_d[7:0];
   assign done = CONV_DONE_I && s.conv;
   assign cnt_on = s.cfg[acd_pkg::STAT_REG][acd_pkg::DCNT_BIT];

   // Data bytes after a write command go to the register, not the decoder
   assign wr_v    = ev_v && ev_k == acd_pkg::K_DATA && s.wr_pend;
   assign cmd_v   = ev_v && !ev_k[1] && !wr_v;
   assign gc_rst  = ev_v && ev_k == acd_pkg::K_GC && ev_b == acd_pkg::GC_RESET;
   assign c_reset = (cmd_v && ev_b[7:1] == acd_pkg::OP_RESET) || gc_rst;
   assign c_start = cmd_v && ev_b[7:1] == acd_pkg::OP_START;
   assign c_sleep = cmd_v && ev_b[7:1] == acd_pkg::OP_SLEEP;
   assign c_fetch = cmd_v && ev_b[7:4] == acd_pkg::OP_FETCH;
   assign c_rdreg = cmd_v && ev_b[7:4] == acd_pkg::OP_RDREG;
   assign c_wrreg = cmd_v && ev_b[7:4] == acd_pkg::OP_WRREG;

   // Status bit is live state, not a stored register bit
   always_comb begin
      rd_val = s.cfg[ev_b[3:2]];
      if (ev_b[3:2] == acd_pkg::STAT_REG) begin
         rd_val[acd_pkg::STAT_BIT] = s.stat;
      end
   end

   always_comb begin
      n = s;
      n.conv_start = 1'h0;
      n.filt_clr = 1'h0;
      if (c_fetch) begin
         n.tx_tgl = ~s.tx_tgl;
         n.rdy = 1'h0;
         n.stat = 1'h0;
         if (s.cfg[acd_pkg::STAT_REG][acd_pkg::DCNT_BIT]) begin
            n.tx_dat = {s.cnt, s.result};
         end else begin
            n.tx_dat = {s.result, 8'h00};
         end
      end
      // Completion after the fetch: the fetch took the older result
      if (done) begin
         n.result = CONV_DATA_I;
         n.cnt = s.cnt + 8'h01;
         n.rdy = 1'h1;
         n.stat = 1'h1;
         n.conv = s.cfg[acd_pkg::MODE_REG][acd_pkg::MODE_BIT] && !s.sleep_pend;
         if (s.sleep_pend) begin
            n.pwr_down = 1'h1;
            n.sleep_pend = 1'h0;
         end
      end
      if (c_rdreg) begin
         n.tx_tgl = ~s.tx_tgl;
         n.tx_dat = {rd_val, 16'h0000};
      end
      if (cmd_v) begin
         n.wr_pend = c_wrreg;
         n.wr_addr = ev_b[3:2];
      end
      if (wr_v) begin
         n.cfg[s.wr_addr] = ev_b;
         n.wr_pend = 1'h0;
         if (s.conv) begin
            n.filt_clr = 1'h1;
            n.conv_start = 1'h1;
         end
      end
      if (c_start) begin
         n.pwr_down = 1'h0;
         n.sleep_pend = 1'h0;
         n.conv = 1'h1;
         n.conv_start = 1'h1;
         if (s.conv) begin
            n.filt_clr = 1'h1;
         end
      end
      // Completion in the same cycle counts as finished, else pend would stick
      if (c_sleep) begin
         if (s.conv && !done) begin
            n.sleep_pend = 1'h1;
         end else begin
            n.pwr_down = 1'h1;
            n.conv = 1'h0;
         end
      end
      // Link side is untouched, so traffic continues at once
      if (c_reset) begin
         n.cfg = {4{acd_pkg::CFG_RST}};
         n.result = 16'h0000;
         n.cnt = 8'h00;
         n.stat = 1'h0;
         n.rdy = 1'h0;
         n.conv = 1'h0;
         n.sleep_pend = 1'h0;
         n.pwr_down = 1'h0;
         n.wr_pend = 1'h0;
         n.conv_start = 1'h0;
         n.filt_clr = 1'h0;
      end
   end

   // Handshake toggles keep their phase across the reset command
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Open drain: the pins only ever pull low
   assign SDA_O        = 1'h0;
   assign RDY_O        = 1'h0;
   assign RDY_OE_O     = s.rdy;
   assign CONV_START_O = s.conv_start;
   assign FILTER_CLR_O = s.filt_clr;
   assign CONVERTING_O = s.conv;
   assign POWER_DOWN_O = s.pwr_down;
   assign CFG_O        = s.cfg;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESET_N_I);

   chk_start_conv: assert property (c_start |=> s.conv && s.conv_start)
      else $error("start command did not start a conversion");
   chk_restart_clear: assert property (c_start && s.conv |=> s.filt_clr)
      else $error("restart did not clear the filter");
   chk_sleep_now: assert property (c_sleep && !s.conv |=> s.pwr_down)
      else $error("idle power-down not taken");
   chk_sleep_defer: assert property (c_sleep && s.conv && !done
      |=> !s.pwr_down && s.sleep_pend)
      else $error("power-down cut a running conversion");
   chk_wake_up: assert property (s.pwr_down && c_start |=> !s.pwr_down ##1 !s.pwr_down)
      else $error("start did not restore analog power");
   chk_fetch_load: assert property (c_fetch && !done
      |=> !s.rdy && s.tx_tgl != $past(s.tx_tgl)
          && s.tx_dat == ($past(cnt_on) ? {$past(s.cnt), $past(s.result)}
                                        : {$past(s.result), 8'h00}))
      else $error("fetch did not load and release ready");
   chk_fetch_race: assert property (c_fetch && done |=> s.rdy && s.stat)
      else $error("result completing at fetch lost its ready");
   chk_ready_set: assert property (done && !c_reset |=> s.rdy)
      else $error("ready pin not pulled on completion");
   chk_status_set: assert property (done && !c_reset |=> s.stat)
      else $error("status bit not set on completion");
   chk_register_read_cmd_value: assert property (c_rdreg |=> s.tx_dat[23:16] == $past(rd_val))
      else $error("register readback loaded wrong value");
   chk_reg_write: assert property (wr_v |=> s.cfg[$past(s.wr_addr)] == $past(ev_b))
      else $error("register write not stored");
   chk_wr_restart: assert property (wr_v && s.conv |=> s.filt_clr && s.conv_start)
      else $error("register write did not restart conversion");
   chk_tx_steady: assert property ($changed(s.tx_tgl) |-> $past(c_fetch) || $past(c_rdreg))
      else $error("output word changed without a command");
   chk_reset_clear: assert property (c_reset |=> s.cfg == '0 && !s.conv && !s.rdy)
      else $error("reset command left state behind");
   chk_gc_reset: assert property (gc_rst |=> s.cfg == '0 && !s.pwr_down)
      else $error("general call reset not applied");
   chk_down_idle: assert property (s.pwr_down |-> !s.conv)
      else $error("converting while powered down");
   chk_cfg_kept: assert property ($rose(s.pwr_down) && !$past(wr_v) |-> $stable(s.cfg))
      else $error("power-down changed a register");
   chk_fetch_clear: assert property (c_fetch && !done |=> !s.stat)
      else $error("fetch left status bit set");
   chk_result_take: assert property (done && !c_reset |=> s.result == $past(CONV_DATA_I))
      else $error("completed result not stored");
   chk_count_step: assert property (done && !c_reset |=> s.cnt == $past(s.cnt) + 8'h01)
      else $error("counter did not step on completion");
   chk_clr_restart: assert property (s.filt_clr |-> s.conv_start)
      else $error("filter cleared without restart");
   chk_ready_drop: assert property ($fell(s.rdy) |-> $past(c_fetch) || $past(c_reset))
      else $error("ready released without fetch");
   chk_wr_select: assert property (c_wrreg |=> s.wr_pend)
      else $error("write command did not arm data byte");
   chk_single_end: assert property (done && !c_reset && !c_start
      && !s.cfg[acd_pkg::MODE_REG][acd_pkg::MODE_BIT] |=> !s.conv)
      else $error("single conversion did not stop");
   chk_cont_keep: assert property (done && !c_reset && !c_sleep && !s.sleep_pend
      && s.cfg[acd_pkg::MODE_REG][acd_pkg::MODE_BIT] |=> s.conv)
      else $error("continuous conversion stopped");
   chk_sleep_done: assert property (done && s.sleep_pend && !c_reset && !c_start
      |=> s.pwr_down && !s.conv)
      else $error("deferred power-down not taken");

   cov_fetch_cnt: cover property (c_fetch && s.cfg[acd_pkg::STAT_REG][acd_pkg::DCNT_BIT]);
   cov_fetch_race: cover property (c_fetch && done);
   cov_sleep_defer: cover property (c_sleep && s.conv ##[1:200] s.pwr_down);
   cov_gc_reset: cover property (gc_rst);
endmodule
`default_nettype wire

/* File: dv/acd_host.sv */
// Serial bus host model facing the decoder's target port
`default_nettype none
module acd_host (
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Slow quarter bit keeps SCL low far above the link's oversampling need
   localparam time Q = 200ns;
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // Start or repeated start; clock idles high between frames
   task automatic start();
      sda_pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b0;
      #(2 * Q);
   endtask
   // Data only changes while SCL is low
   task automatic bit_io(input logic b, output logic r);
      sda_pull_o = ~b;
      #Q scl_o = 1'b1;
      #Q r = sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the command decoder
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] ADR = acd_pkg::DEV_ADDR_DEF;
   logic        clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, done = 1'b0;
   logic [15:0] cdat = 16'h0000;
   logic        scl, pull, sda_o, oe, cstart, fclr, conv, pdn, rdy_oe, ack, rdy_pin;
   logic [31:0] cfg;
   logic [7:0]  b0, b1, b2;
   wire logic   sda;
   int          error_cnt = 0, n_tests = 0, n_start = 0, n_clr = 0;
   // Pull-up wins unless someone pulls low
   assign sda = pull ? 1'b0 : (oe ? sda_o : 1'b1);
   always #12.5 clk = ~clk;
   initial begin
      #3.1;
      forever #7.5 lclk = ~lclk;
   end
   acd_cmd_decoder DUT (
      .CLK_SYS_I    (clk),
      .RESET_N_I    (rst_n),
      .LINK_CLK_I   (lclk),
      .SCL_I        (scl),
      .SDA_I        (sda),
      .SDA_O        (sda_o),
      .SDA_OE_O     (oe),
      .CONV_DONE_I  (done),
      .CONV_DATA_I  (cdat),
      .CONV_START_O (cstart),
      .FILTER_CLR_O (fclr),
      .CONVERTING_O (conv),
      .POWER_DOWN_O (pdn),
      .RDY_O        (rdy_pin),
      .RDY_OE_O     (rdy_oe),
      .CFG_O        (cfg)
   );
   acd_host h (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
   // Pulses come mid-transfer, so they are counted rather than awaited
   always @(posedge clk) begin
      if (cstart === 1'b1) n_start++;
      if (fclr === 1'b1) n_clr++;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wb(input logic [7:0] d);
      h.wbyte(d, ack);
      chkb("ack", 1'b0, ack);
   endtask
   // Leaves the frame open so a repeated start can follow
   task automatic cmd(input logic [7:0] c);
      h.start();
      wb({ADR, 1'b0});
      wb(c);
   endtask
   task automatic rd(input int n);
      h.start();
      wb({ADR, 1'b1});
      h.rbyte(n == 1, b0);
      if (n > 1) h.rbyte(n == 2, b1);
      if (n > 2) h.rbyte(1'b1, b2);
      h.stop();
   endtask
   // Ignored low bit sent as one
   task automatic op(input logic [6:0] o);
      cmd({o, 1'b1});
      h.stop();
   endtask
   task automatic register_write_cmd(input logic [1:0] a, input logic [7:0] d);
      cmd({acd_pkg::OP_WRREG, a, 2'h0});
      wb(d);
      h.stop();
   endtask
   task automatic register_read_cmd(input logic [1:0] a);
      cmd({acd_pkg::OP_RDREG, a, 2'h3});
      rd(1);
   endtask
   task automatic fetch(input int n);
      cmd({acd_pkg::OP_FETCH, 4'hF});
      rd(n);
   endtask
   task automatic cdone(input logic [15:0] d);
      @(posedge clk);
      #2 done = 1'b1;
      cdat = d;
      @(posedge clk);
      #2 done = 1'b0;
      repeat (3) @(posedge clk);
      #2;
   endtask
   task automatic t_reset();
      chk("cfg", 32'h0, cfg);
      chkb("pdn", 1'b0, pdn);
      chkb("rdy", 1'b0, rdy_oe);
      chkb("rdy pin", 1'b0, rdy_pin);
      $display("t_reset done");
   endtask
   task automatic t_register_write_cmd();
      cmd({acd_pkg::OP_WRREG, 2'h0, 2'h0});
      wb(8'hA5);
      wb({acd_pkg::OP_WRREG, 2'h3, 2'h0});
      wb(8'h3C);
      h.stop();
      chk("cfg", 32'h3C0000A5, cfg);
      register_read_cmd(2'h3);
      chk("reg3", 32'h3C, {24'h0, b0});
      register_read_cmd(2'h0);
      chk("reg0", 32'hA5, {24'h0, b0});
      $display("t_register_write_cmd done");
   endtask
   task automatic t_single();
      int s, c;
      s = n_start;
      c = n_clr;
      op(acd_pkg::OP_START);
      chk("start", s + 1, n_start);
      chkb("conv", 1'b1, conv);
      op(acd_pkg::OP_START);
      chk("resync", c + 1, n_clr);
      chk("restart", s + 2, n_start);
      cdone(16'h1234);
      chkb("rdy", 1'b1, rdy_oe);
      chkb("single end", 1'b0, conv);
      register_read_cmd(acd_pkg::STAT_REG);
      chk("status", 32'h1 << acd_pkg::STAT_BIT, {24'h0, b0});
      fetch(2);
      chk("result", 32'h1234, {16'h0, b0, b1});
      chkb("rdy off", 1'b0, rdy_oe);
      $display("t_single done");
   endtask
   task automatic t_cont();
      int c;
      c = n_clr;
      register_write_cmd(acd_pkg::MODE_REG, 8'h10);
      chk("idle write", c, n_clr);
      op(acd_pkg::OP_START);
      op(acd_pkg::OP_START);
      chk("resync", c + 1, n_clr);
      register_write_cmd(acd_pkg::STAT_REG, 8'h40);
      chk("wr restart", c + 2, n_clr);
      chkb("conv", 1'b1, conv);
      cdone(16'hBEEF);
      cmd({acd_pkg::OP_FETCH, 4'h0});
      fork
         rd(3);
         begin
            #10us;
            cdone(16'h1111);
         end
      join
      chk("counted", 32'h02BEEF, {8'h0, b0, b1, b2});
      chkb("rdy new", 1'b1, rdy_oe);
      fetch(3);
      chk("next", 32'h031111, {8'h0, b0, b1, b2});
      // Completion inside the command byte; the pin tells which result left
      fork
         fetch(3);
         begin
            #14us;
            cdone(16'h4444);
         end
      join
      if (rdy_oe) chk("old kept", 32'h031111, {8'h0, b0, b1, b2});
      else chk("new taken", 32'h044444, {8'h0, b0, b1, b2});
      $display("t_cont done");
   endtask
   task automatic t_sleep();
      op(acd_pkg::OP_SLEEP);
      chkb("pdn wait", 1'b0, pdn);
      cdone(16'h2222);
      chkb("pdn", 1'b1, pdn);
      chkb("conv", 1'b0, conv);
      chk("cfg kept", 32'h3C4010A5, cfg);
      op(acd_pkg::OP_START);
      chkb("wake", 1'b0, pdn);
      $display("t_sleep done");
   endtask
   task automatic t_rst();
      op(acd_pkg::OP_RESET);
      chk("cfg", 32'h0, cfg);
      chkb("conv", 1'b0, conv);
      chkb("rdy", 1'b0, rdy_oe);
      register_read_cmd(2'h1);
      chk("reg1", 32'h0, {24'h0, b0});
      register_write_cmd(2'h0, 8'h5A);
      chk("cfg", 32'h5A, cfg);
      h.start();
      wb({acd_pkg::GC_ADDR, 1'b0});
      wb(acd_pkg::GC_RESET);
      h.stop();
      chk("gc reset", 32'h0, cfg);
      h.start();
      h.wbyte({acd_pkg::GC_ADDR, 1'b1}, ack);
      chkb("gc read", 1'b1, ack);
      h.stop();
      $display("t_rst done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #2 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      t_reset();
      t_register_write_cmd();
      t_single();
      t_cont();
      t_sleep();
      t_rst();
      end_sim();
   end
   // A hung run still reaches the verdict
   initial begin
      #2ms;
      error_cnt++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      end_sim();
   end
endmodule
`default_nettype wire
